// ### rtl/pad_common_fault_status_bank.sv
// status readback bank: pad levels, common flags, extra faults, first fault record
//
// How it works
// - pad register shows raw synchronised levels in bits9:0, own drives in bits15:10
// - bit15 zero while power-good driven low
// - bit14 zero while alert driven low
// - bits13:12 fault bus drives, bus0 upper
// - bits11:10 good drives, channel1 upper
// - bits9:8 select1 high/float/low code
// - bits7:6 select0 same code
// - on/off bits5:4, good levels bits1:0
// - bits3:2 sensed fault bus levels
// - busy device answers only common status
// - busy refusal nacks, sets busy, pulls alert
// - common bit7 mirrors alert line
// - common bit6 one when ready
// - common bits5:2 read as ones
// - bit1 timebase idle low, bit0 write-protect
// - sticky bits clear on clear or turn-on
// - extra fault bits15:3 read zero
// - short cycle sticky alerting paged bit2
// - bit1 shows auxiliary fault drive
// - bit0 input undervoltage turn-off, no alert
// - first fault captured, cleared to zero
// - timestamp snapshot of timer low byte
// - record holds page, bit, command code
`timescale 1ns/1ps
`default_nettype none
`include "pad_status_defines.svh"
module pad_common_fault_status_bank
   import pad_status_pkg::*;
#(
   parameter int unsigned SHARE_IDLE_CYCLES = `SHARE_IDLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // pads sensed from outside
   input wire logic fault_bus0_pin,
   input wire logic fault_bus1_pin,
   input wire logic chan0_good_pin,
   input wire logic chan1_good_pin,
   input wire logic chan0_onoff_pin,
   input wire logic chan1_onoff_pin,
   input wire logic addr_select0_pin,
   input wire logic addr_select1_pin,
   input wire logic addr_select0_float,
   input wire logic addr_select1_float,
   input wire logic share_clk_pin,
   input wire logic write_protect_pin,
   // own pull-low drives, active high means pulling low
   input wire logic pwrgd_pull,
   input wire logic fault_bus0_pull,
   input wire logic fault_bus1_pull,
   input wire logic chan0_good_pull,
   input wire logic chan1_good_pull,
   input wire logic aux_fault_pull,
   input wire logic other_alert,
   // device state and events
   input wire logic busy,
   input wire logic page,
   input wire logic clear_faults,
   input wire logic [1:0] chan_turn_on,
   input wire logic [1:0] chan_seq_off_busy,
   input wire logic [1:0] chan_vin_off,
   input wire logic fault_event,
   input wire fault_code_t fault_code,
   input wire logic [7:0] shared_timer,
   // command read port
   input wire read_req_t req,
   output read_rsp_t rsp,
   // status outputs
   output logic alert_n,
   output logic busy_flag,
   output logic first_fault_valid,
   output logic [7:0] first_fault_timestamp
);
   logic rst_a, rst_b;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_a <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_b <= rst_a;
      end
   end
   wire logic srst_n = rst_b;

   // two-flop synchronisers on every pad
   localparam int NPAD = 12;
   logic [NPAD-1:0] pad_raw, pad_s1, pad_s2;
   assign pad_raw = {write_protect_pin, share_clk_pin, addr_select1_float, addr_select0_float,
                     addr_select1_pin, addr_select0_pin, chan1_onoff_pin, chan0_onoff_pin,
                     chan1_good_pin, chan0_good_pin, fault_bus1_pin, fault_bus0_pin};
   genvar gi;
   generate
      for (gi = 0; gi < NPAD; gi++) begin : g_sync
         always_ff @(posedge clk or negedge srst_n) begin
            if (!srst_n) begin
               pad_s1[gi] <= 1'b0;
               pad_s2[gi] <= 1'b0;
            end else begin
               pad_s1[gi] <= pad_raw[gi];
               pad_s2[gi] <= pad_s1[gi];
            end
         end
      end
   endgenerate

   function automatic logic [1:0] asel_code(input logic lvl, input logic flt);
      if (flt)
         asel_code = `ASEL_FLOAT;
      else if (lvl)
         asel_code = `ASEL_HIGH;
      else
         asel_code = `ASEL_LOW;
   endfunction

   // share clock edge watchdog: held low when the line stays low with no edge for a long time
   logic share_d;
   logic [31:0] share_cnt;
   logic share_held_low;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         share_d <= 1'b0;
         share_cnt <= 32'd0;
         share_held_low <= 1'b1;
      end else begin
         share_d <= pad_s2[10];
         if (pad_s2[10] != share_d || pad_s2[10]) begin
            share_cnt <= 32'd0;
            share_held_low <= 1'b0;
         end else if (share_cnt >= SHARE_IDLE_CYCLES - 1) begin
            share_held_low <= 1'b1;
         end else begin
            share_cnt <= share_cnt + 32'd1;
         end
      end
   end

   // busy refusal: nack sets busy flag, cleared by clear-faults
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n)
         busy_flag <= 1'b0;
      else if (req.valid && busy && req.cmd != `CMD_COMMON_STATUS)
         busy_flag <= 1'b1;
      else if (clear_faults)
         busy_flag <= 1'b0;
   end

   // extra fault sticky bits, per channel
   logic [1:0] short_cycle, vin_caused_off;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_chan
         always_ff @(posedge clk or negedge srst_n) begin
            if (!srst_n) begin
               short_cycle[gi] <= 1'b0;
               vin_caused_off[gi] <= 1'b0;
            end else begin
               if (chan_turn_on[gi] && chan_seq_off_busy[gi])
                  short_cycle[gi] <= 1'b1;
               else if (clear_faults || chan_turn_on[gi])
                  short_cycle[gi] <= 1'b0;
               if (chan_vin_off[gi])
                  vin_caused_off[gi] <= 1'b1;
               else if (clear_faults || chan_turn_on[gi])
                  vin_caused_off[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // first fault record and timestamp; set wins over clear
   fault_code_t first_fault;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         first_fault <= `FIRST_FAULT_NONE;
         first_fault_valid <= 1'b0;
         first_fault_timestamp <= `STAMP_RESET;
      end else if (fault_event && !first_fault_valid) begin
         first_fault <= fault_code;
         first_fault_valid <= 1'b1;
         first_fault_timestamp <= shared_timer;
      end else if (clear_faults || chan_turn_on != 2'b00) begin
         first_fault <= `FIRST_FAULT_NONE;
         first_fault_valid <= 1'b0;
         first_fault_timestamp <= `STAMP_RESET;
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n)
         alert_n <= 1'b1;
      else
         alert_n <= ~(other_alert | busy_flag | (|short_cycle));
   end

   // coherent register images built from clock-domain values
   logic [15:0] pad_word, extra_word;
   logic [7:0] common_byte;
   always_comb begin
      pad_word = {~pwrgd_pull,
                  ~alert_n ? 1'b0 : 1'b1,
                  ~fault_bus0_pull, ~fault_bus1_pull,
                  ~chan1_good_pull, ~chan0_good_pull,
                  asel_code(pad_s2[7], pad_s2[9]),
                  asel_code(pad_s2[6], pad_s2[8]),
                  pad_s2[5], pad_s2[4],
                  pad_s2[0], pad_s2[1],
                  pad_s2[3], pad_s2[2]};
      common_byte = {alert_n,
                     ~busy,
                     `COMMON_ONES,
                     share_held_low, pad_s2[11]};
      extra_word = {13'h0000,
                    short_cycle[page], aux_fault_pull,
                    vin_caused_off[page]};
   end

   // read port: one answer cycle after each accepted request
   rd_state_t st;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         st <= rd_idle;
         rsp <= '0;
      end else begin
         rsp.valid <= 1'b0;
         rsp.ack <= 1'b0;
         st <= rd_idle;
         if (req.valid) begin
            rsp.valid <= 1'b1;
            if (busy && req.cmd != `CMD_COMMON_STATUS) begin
               st <= rd_refuse;
               rsp.data <= 16'h0000;
            end else begin
               st <= rd_answer;
               rsp.ack <= 1'b1;
               case (req.cmd)
                  `CMD_PAD_READBACK: rsp.data <= pad_word;
                  `CMD_COMMON_STATUS: rsp.data <= {8'h00, common_byte};
                  `CMD_EXTRA_FAULT: rsp.data <= extra_word;
                  `CMD_FIRST_FAULT: rsp.data <= first_fault;
                  default: begin
                     rsp.ack <= 1'b0;
                     rsp.data <= 16'h0000;
                  end
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### common/pad_status_defines.svh
// constants for the pad, common, extra fault and first fault status bank
`ifndef PAD_STATUS_DEFINES_SVH
`define PAD_STATUS_DEFINES_SVH
`define CMD_PAD_READBACK 8'h01
`define CMD_COMMON_STATUS 8'h02
`define CMD_EXTRA_FAULT 8'h03
`define CMD_FIRST_FAULT 8'h04
`define ASEL_HIGH 2'h3
`define ASEL_FLOAT 2'h2
`define ASEL_LOW 2'h0
`define COMMON_ONES 4'hf
`define PAGE_GLOBAL 4'hf
`define FIRST_FAULT_NONE 16'h0000
`define STAMP_RESET 8'h00
`define SHARE_IDLE_NS 32'd10000
`define SHARE_IDLE_CYCLES ((`SHARE_IDLE_NS + 32'd3) / 32'd4)
`endif

// ### common/pad_status_pkg.sv
// types for the pad, common, extra fault and first fault status bank
package pad_status_pkg;
   typedef enum logic [1:0] {
      rd_idle = 2'b00,
      rd_answer = 2'b01,
      rd_refuse = 2'b10
   } rd_state_t;
   typedef struct packed {
      logic [3:0] page;
      logic [3:0] bit_num;
      logic [7:0] cmd;
   } fault_code_t;
   typedef struct packed {
      logic valid;
      logic [7:0] cmd;
   } read_req_t;
   typedef struct packed {
      logic valid;
      logic ack;
      logic [15:0] data;
   } read_rsp_t;
endpackage

// ### testbench/pad_status_host.sv
// host model issuing one-cycle read requests to the status bank
`timescale 1ns/1ps
`default_nettype none
module pad_status_host
   import pad_status_pkg::*;
(
   // read port
   input wire logic clk,
   output read_req_t req,
   input wire read_rsp_t rsp
);
   initial req = '0;
   // request stands one cycle; the answer is taken at the edge after it is accepted
   task automatic rd(input logic [7:0] c, output logic [17:0] r);
      @(posedge clk);
      req <= '{valid: 1'b1, cmd: c};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      r = {rsp.valid, rsp.ack, rsp.data};
   endtask
endmodule
`default_nettype wire

// ### testbench/pad_status_bank_checker.sv
// port assertions for the status bank
`timescale 1ns/1ps
`default_nettype none
module pad_status_bank_checker
   import pad_status_pkg::*;
(
   // watched ports
   input wire logic clk,
   input wire logic rstn,
   input wire logic busy,
   input wire logic clear_faults,
   input wire logic [1:0] chan_turn_on,
   input wire logic fault_event,
   input wire logic [7:0] shared_timer,
   input wire read_req_t req,
   input wire read_rsp_t rsp,
   input wire logic alert_n,
   input wire logic busy_flag,
   input wire logic first_fault_valid,
   input wire logic [7:0] first_fault_timestamp
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_ans; req.valid |=> rsp.valid; endproperty
   a_ans: assert property (p_ans) else $error("request not answered");
   property p_com; req.valid && req.cmd == 8'h02
      |=> rsp.ack && rsp.data[15:8] == 8'h00 && rsp.data[5:2] == 4'hf; endproperty
   a_com: assert property (p_com) else $error("common status word wrong");
   property p_ref; req.valid && busy && req.cmd != 8'h02
      |=> !rsp.ack ##[0:1] (busy_flag && !alert_n);
   endproperty
   a_ref: assert property (p_ref) else $error("busy refusal wrong");
   property p_ext; req.valid && req.cmd == 8'h03 |=> rsp.data[15:3] == 13'h0; endproperty
   a_ext: assert property (p_ext) else $error("extra fault upper bits set");
   property p_clr; clear_faults && !fault_event |=> !first_fault_valid && first_fault_timestamp == 8'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("record not cleared");
   property p_cap; fault_event && !first_fault_valid
      |=> first_fault_valid && first_fault_timestamp == $past(shared_timer); endproperty
   a_cap: assert property (p_cap) else $error("timestamp not captured");
   property p_hold; first_fault_valid && !clear_faults && chan_turn_on == 2'h0
      |=> first_fault_valid && $stable(first_fault_timestamp); endproperty
   a_hold: assert property (p_hold) else $error("first fault overwritten");
   property p_bsy; busy_flag && !clear_faults |=> busy_flag; endproperty
   a_bsy: assert property (p_bsy) else $error("busy flag dropped");
endmodule
bind pad_common_fault_status_bank pad_status_bank_checker u_pad_status_bank_checker (.clk(clk),
   .rstn(rstn), .busy(busy), .clear_faults(clear_faults), .chan_turn_on(chan_turn_on),
   .fault_event(fault_event), .shared_timer(shared_timer), .req(req), .rsp(rsp),
   .alert_n(alert_n), .busy_flag(busy_flag), .first_fault_valid(first_fault_valid),
   .first_fault_timestamp(first_fault_timestamp));
`default_nettype wire

// ### testbench/test_pad_common_fault_status_bank.sv
// self-checking bench for the status bank
`timescale 1ns/1ps
`default_nettype none
module test_pad_common_fault_status_bank;
   import pad_status_pkg::*;
   logic clk = 0, rstn = 0, sclk = 0, srun = 1, wp = 0, aux = 0, busy = 0, page = 0;
   logic clr_f = 0, fev = 0, alert_n, busy_flag, ffv;
   logic [14:0] pads = '0;
   logic [1:0] ton = 0, seq = 0, vin = 0;
   logic [7:0] tmr = 0, ffts;
   fault_code_t fcode = '0;
   read_req_t req;
   read_rsp_t rsp;
   int failures = 0, n_checks = 0, cycles = 0;
   pad_common_fault_status_bank #(.SHARE_IDLE_CYCLES(40)) u_pad_common_fault_status_bank (
      .clk(clk), .rstn(rstn), .fault_bus0_pin(pads[3]), .fault_bus1_pin(pads[2]),
      .chan0_good_pin(pads[0]), .chan1_good_pin(pads[1]), .chan0_onoff_pin(pads[4]),
      .chan1_onoff_pin(pads[5]), .addr_select0_pin(pads[6]), .addr_select1_pin(pads[8]),
      .addr_select0_float(pads[7]), .addr_select1_float(pads[9]), .share_clk_pin(sclk),
      .write_protect_pin(wp), .pwrgd_pull(pads[14]), .fault_bus0_pull(pads[13]),
      .fault_bus1_pull(pads[12]), .chan0_good_pull(pads[10]), .chan1_good_pull(pads[11]),
      .aux_fault_pull(aux), .other_alert(1'b0), .busy(busy), .page(page), .clear_faults(clr_f),
      .chan_turn_on(ton), .chan_seq_off_busy(seq), .chan_vin_off(vin), .fault_event(fev),
      .fault_code(fcode), .shared_timer(tmr), .req(req), .rsp(rsp), .alert_n(alert_n),
      .busy_flag(busy_flag), .first_fault_valid(ffv), .first_fault_timestamp(ffts));
   pad_status_host u_pad_status_host (.clk(clk), .req(req), .rsp(rsp));
   always #2 clk = ~clk;
   // shared timebase stands low once stopped
   always #62.5 sclk <= srun & ~sclk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         close_out();
      end
   end
   task automatic close_out;
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] c, input logic [17:0] e);
      logic [17:0] r;
      u_pad_status_host.rd(c, r);
      chk(nm, r, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic clr;
      @(posedge clk) clr_f <= 1;
      @(posedge clk) clr_f <= 0;
   endtask
   function automatic logic [1:0] sel(input logic [1:0] fp);
      return fp[1] ? 2'h2 : {fp[0], fp[0]};
   endfunction
   task automatic t_pads;
      logic [14:0] v [4] = '{15'h5555, 15'h2aaa, 15'h0000, 15'h7fff};
      foreach (v[i]) begin
         @(posedge clk) pads <= v[i];
         cyc(4);
         rdc("pads", 8'h01, {2'b11, ~v[i][14], 1'b1, ~v[i][13], ~v[i][12], ~v[i][11],
            ~v[i][10], sel(v[i][9:8]), sel(v[i][7:6]), v[i][5:0]});
      end
   endtask
   task automatic t_common;
      @(posedge clk) wp <= 1;
      cyc(4);
      rdc("common run", 8'h02, 18'h300fd);
      @(posedge clk) wp <= 0;
      srun <= 0;
      cyc(80);
      rdc("common idle", 8'h02, 18'h300fe);
   endtask
   task automatic t_busy;
      @(posedge clk) busy <= 1;
      cyc(2);
      rdc("busy common", 8'h02, 18'h300be);
      rdc("refused", 8'h04, 18'h20000);
      cyc(2);
      chk("flag", {16'h0, busy_flag, alert_n}, 18'h2);
      rdc("alert common", 8'h02, 18'h3003e);
      @(posedge clk) busy <= 0;
      clr();
      cyc(3);
      rdc("ready", 8'h02, 18'h300fe);
   endtask
   task automatic t_extra;
      logic [17:0] r;
      @(posedge clk) seq <= 2'h1;
      aux <= 1;
      ton <= 2'h1;
      @(posedge clk) ton <= 0;
      seq <= 0;
      vin <= 2'h1;
      @(posedge clk) vin <= 0;
      cyc(2);
      rdc("extra ch0", 8'h03, 18'h30007);
      chk("extra alert", {17'h0, alert_n}, 18'h0);
      @(posedge clk) page <= 1;
      rdc("extra ch1", 8'h03, 18'h30002);
      @(posedge clk) page <= 0;
      aux <= 0;
      clr();
      cyc(2);
      u_pad_status_host.rd(8'h03, r);
      chk("extra cleared", {14'h0, r[17], r[2:1], alert_n}, 18'h9);
   endtask
   task automatic t_first;
      @(posedge clk) tmr <= 8'h5a;
      fcode <= '{4'h1, 4'h3, 8'h80};
      fev <= 1;
      @(posedge clk) tmr <= 8'h11;
      fcode <= '{4'hf, 4'h2, 8'h7c};
      @(posedge clk) fev <= 0;
      cyc(1);
      chk("stamp", {9'h0, ffv, ffts}, 18'h15a);
      rdc("first", 8'h04, 18'h31380);
      clr();
      cyc(1);
      chk("stamp clr", {9'h0, ffv, ffts}, 18'h0);
      rdc("first clr", 8'h04, 18'h30000);
      @(posedge clk) fev <= 1;
      @(posedge clk) fev <= 0;
      cyc(1);
      rdc("global", 8'h04, 18'h3f27c);
      @(posedge clk) ton <= 2'h2;
      @(posedge clk) ton <= 0;
      cyc(1);
      rdc("turn on", 8'h04, 18'h30000);
   endtask
   initial begin
      cyc(8);
      rstn <= 1;
      cyc(3);
      t_pads();
      t_common();
      t_busy();
      t_extra();
      t_first();
      close_out();
   end
endmodule
`default_nettype wire
